// [hdl/shp_pkg.sv]
// Constants, types and helpers shared by the serial host port.
package shp_pkg;
    localparam longint unsigned CLK_HZ       = 64'd100_000_000;
    localparam int              BIT_W        = 17;
    localparam int              CNT_W        = 25;
    localparam int              BUF_DEPTH    = 2048;
    localparam int              BUF_AW       = 11;
    localparam longint unsigned STANDBY_INIT_N_MIN_MS  = 64'd250;
    localparam int unsigned     STANDBY_INIT_N_MIN_CYC = int'(STANDBY_INIT_N_MIN_MS * CLK_HZ / 64'd1000);
    localparam longint unsigned WAKE_MIN_NS  = 64'd250;
    localparam int unsigned     WAKE_MIN_CYC =
        int'((WAKE_MIN_NS * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000);
    localparam longint unsigned ACK_NS       = 64'd1000;
    localparam int unsigned     ACK_CYC      = int'(ACK_NS * CLK_HZ / 64'd1_000_000_000);
    localparam longint unsigned AUTO_MAX_BAUD = 64'd460_800;
    localparam logic [BIT_W-1:0] AUTO_MIN_CYC = BIT_W'(CLK_HZ / AUTO_MAX_BAUD);
    localparam logic [2:0]      BAUD_AUTO    = 3'h7;
    localparam longint unsigned DEF_BAUD     = 64'd9600;

    typedef enum logic [1:0] {
        SHP_RUN  = 2'b00,
        SHP_STANDBY_INIT_N = 2'b01,
        SHP_INIT = 2'b10
    } shp_mode_t;

    typedef enum logic [1:0] {
        SHP_S_IDLE  = 2'b00,
        SHP_S_START = 2'b01,
        SHP_S_DATA  = 2'b10,
        SHP_S_STOP  = 2'b11
    } shp_bit_t;

    // Bit time in clock cycles for a strapped rate.
    function automatic logic [BIT_W-1:0] baud_bit_cycles(input logic [2:0] sel);
        longint unsigned rate;
        case (sel)
            3'h0: rate = 64'd1200;
            3'h1: rate = 64'd2400;
            3'h2: rate = 64'd4800;
            3'h3: rate = 64'd9600;
            3'h4: rate = 64'd19200;
            3'h5: rate = 64'd38400;
            3'h6: rate = 64'd57600;
            default: rate = DEF_BAUD;
        endcase
        return BIT_W'(CLK_HZ / rate);
    endfunction : baud_bit_cycles
endpackage : shp_pkg

// [hdl/shp_uart_if.sv]
// Link between the port core and its serial receiver and transmitter.
interface shp_uart_if;
    logic [shp_pkg::BIT_W-1:0] bit_cyc;
    logic                      en;
    logic [7:0]                rx_data;
    logic                      rx_valid;
    logic [7:0]                tx_data;
    logic                      tx_start;
    logic                      tx_busy;

    modport core (output bit_cyc, en, tx_data, tx_start,
                  input  rx_data, rx_valid, tx_busy);
    modport rx   (input  bit_cyc, en, output rx_data, rx_valid);
    modport tx   (input  bit_cyc, en, tx_data, tx_start, output tx_busy);
endinterface : shp_uart_if

// [hdl/shp_uart_rx.sv]
// Asynchronous serial receiver with mid-bit sampling.
module shp_uart_rx (
    input  wire logic   clk_sys_i,
    input  wire logic   srst_i,
    input  wire logic   rxd_i,
    shp_uart_if.rx      lnk
);
    shp_pkg::shp_bit_t         st_q, st_d;
    logic [shp_pkg::BIT_W-1:0] cnt_q, cnt_d;
    logic [2:0]                idx_q, idx_d;
    logic [7:0]                sh_q, sh_d;
    logic                      vld_q, vld_d;
    logic                      last;

    assign last = (cnt_q == lnk.bit_cyc - 1'b1);

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q + 1'b1;
        idx_d = idx_q;
        sh_d  = sh_q;
        vld_d = 1'b0;
        case (st_q)
            shp_pkg::SHP_S_IDLE: begin
                cnt_d = '0;
                if (!rxd_i) begin
                    st_d = shp_pkg::SHP_S_START;
                end
            end
            shp_pkg::SHP_S_START: begin
                if (cnt_q == (lnk.bit_cyc >> 1)) begin
                    cnt_d = '0;
                    idx_d = '0;
                    st_d  = rxd_i ? shp_pkg::SHP_S_IDLE : shp_pkg::SHP_S_DATA;
                end
            end
            shp_pkg::SHP_S_DATA: begin
                if (last) begin
                    cnt_d = '0;
                    sh_d  = {rxd_i, sh_q[7:1]};
                    idx_d = idx_q + 1'b1;
                    if (idx_q == 3'h7) begin
                        st_d = shp_pkg::SHP_S_STOP;
                    end
                end
            end
            shp_pkg::SHP_S_STOP: begin
                if (last) begin
                    vld_d = rxd_i;
                    st_d  = shp_pkg::SHP_S_IDLE;
                end
            end
            default: st_d = shp_pkg::SHP_S_IDLE;
        endcase
        if (!lnk.en) begin
            st_d  = shp_pkg::SHP_S_IDLE;
            vld_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            st_q  <= shp_pkg::SHP_S_IDLE;
            cnt_q <= '0;
            idx_q <= '0;
            sh_q  <= '0;
            vld_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            sh_q  <= sh_d;
            vld_q <= vld_d;
        end
    end

    assign lnk.rx_data  = sh_q;
    assign lnk.rx_valid = vld_q;
endmodule : shp_uart_rx

// [hdl/shp_uart_tx.sv]
// Asynchronous serial transmitter, start, eight data bits and one stop bit.
module shp_uart_tx (
    input  wire logic   clk_sys_i,
    input  wire logic   srst_i,
    output logic        txd_o,
    shp_uart_if.tx      lnk
);
    shp_pkg::shp_bit_t         st_q, st_d;
    logic [shp_pkg::BIT_W-1:0] cnt_q, cnt_d;
    logic [2:0]                idx_q, idx_d;
    logic [7:0]                sh_q, sh_d;
    logic                      txd_q, txd_d;
    logic                      last;

    assign last = (cnt_q == lnk.bit_cyc - 1'b1);

    always_comb begin
        st_d  = st_q;
        cnt_d = last ? '0 : cnt_q + 1'b1;
        idx_d = idx_q;
        sh_d  = sh_q;
        txd_d = txd_q;
        case (st_q)
            shp_pkg::SHP_S_IDLE: begin
                cnt_d = '0;
                txd_d = 1'b1;
                if (lnk.tx_start) begin
                    sh_d  = lnk.tx_data;
                    txd_d = 1'b0;
                    st_d  = shp_pkg::SHP_S_START;
                end
            end
            shp_pkg::SHP_S_START: begin
                if (last) begin
                    txd_d = sh_q[0];
                    sh_d  = {1'b0, sh_q[7:1]};
                    idx_d = '0;
                    st_d  = shp_pkg::SHP_S_DATA;
                end
            end
            shp_pkg::SHP_S_DATA: begin
                if (last) begin
                    idx_d = idx_q + 1'b1;
                    txd_d = sh_q[0];
                    sh_d  = {1'b0, sh_q[7:1]};
                    if (idx_q == 3'h7) begin
                        txd_d = 1'b1;
                        st_d  = shp_pkg::SHP_S_STOP;
                    end
                end
            end
            shp_pkg::SHP_S_STOP: begin
                if (last) begin
                    st_d = shp_pkg::SHP_S_IDLE;
                end
            end
            default: st_d = shp_pkg::SHP_S_IDLE;
        endcase
        if (!lnk.en) begin
            st_d  = shp_pkg::SHP_S_IDLE;
            txd_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            st_q  <= shp_pkg::SHP_S_IDLE;
            cnt_q <= '0;
            idx_q <= '0;
            sh_q  <= '0;
            txd_q <= 1'b1;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            sh_q  <= sh_d;
            txd_q <= txd_d;
        end
    end

    assign txd_o       = txd_q;
    assign lnk.tx_busy = (st_q != shp_pkg::SHP_S_IDLE);
endmodule : shp_uart_tx

// [hdl/shp_serial_port.sv]
// Serial host port with flow control, baud selection and standby control.
// Functional notes
// - Serial bytes in on receive, out on transmit.
// - Clear-to-send low while another byte fits.
// - Clear-to-send pulses high after each byte.
// - Full buffer holds clear-to-send high.
// - Baud detect input measures host bit time.
// - Strap pins set receive and transmit rate.
// - All straps high selects automatic baud.
// - Standby pin low 250 ms enters standby.
// - Standby forces handshakes not-ready, flushes buffer.
// - Standby ignores all inputs but standby pin and converter clear.
// - Standby pin high returns to idle mode.
// - Sleep standby wakes on 250 ns pulse.
// - Shorter low pulse starts parameter initialization.
// - Initialization restores defaults, keeps recorded audio.
// - Version announced after initialization completes.
// - Reset halts activity, outputs to defined state.
// - Outputs valid within 2 ms of reset.
// - Converter clear low initializes converters.
module shp_serial_port #(
    parameter int unsigned STANDBY_INIT_N_MIN_CYCLES = shp_pkg::STANDBY_INIT_N_MIN_CYC
) (
    input  wire logic       clk_sys_i,
    input  wire logic       srst_i,
    input  wire logic       rxd_i,
    output logic            txd_o,
    output logic            cts_n_o,
    input  wire logic       baud_detect_in_i,
    input  wire logic [2:0] baud_select_i,
    input  wire logic       standby_init_n_i,
    input  wire logic       converter_clear_n_i,
    input  wire logic       sleep_event_i,
    output logic [7:0]      buf_data_o,
    output logic            buf_valid_o,
    input  wire logic       buf_ready_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o,
    output logic            param_init_o,
    input  wire logic       param_init_done_i,
    output logic            announce_version_o,
    output logic            standby_o,
    output logic            converter_init_o
);
    shp_uart_if lnk ();

    // Mode control state.
    shp_pkg::shp_mode_t        mode_q, mode_d;
    logic [shp_pkg::CNT_W-1:0] low_q, low_d;
    logic                      armed_q, armed_d;
    logic                      sleep_q, sleep_d;
    logic                      init_q, init_d;
    logic                      ann_q, ann_d;
    logic                      flush;
    logic                      run;

    // Baud detection state.
    logic                      bd_prev_q, bd_prev_d;
    logic [shp_pkg::BIT_W-1:0] bd_run_q, bd_run_d;
    logic [shp_pkg::BIT_W-1:0] bd_best_q, bd_best_d;

    // Buffer and handshake state.
    logic [7:0]                mem [shp_pkg::BUF_DEPTH];
    logic [shp_pkg::BUF_AW:0]  wr_q, wr_d;
    logic [shp_pkg::BUF_AW:0]  rd_q, rd_d;
    logic [shp_pkg::BUF_AW:0]  fill;
    logic                      full;
    logic                      wr_en;
    logic [7:0]                out_q, out_d;
    logic                      ov_q, ov_d;
    logic [7:0]                ack_q, ack_d;
    logic                      cts_n_q, cts_n_d;
    logic                      conv_q, conv_d;
    logic                      start_q, start_d;
    logic [7:0]                txb_q, txb_d;

    assign run   = (mode_q != shp_pkg::SHP_STANDBY_INIT_N);
    assign flush = (mode_d == shp_pkg::SHP_STANDBY_INIT_N);

    always_comb begin
        mode_d  = mode_q;
        low_d   = low_q;
        armed_d = armed_q | standby_init_n_i;
        sleep_d = sleep_q;
        init_d  = 1'b0;
        ann_d   = 1'b0;
        case (mode_q)
            shp_pkg::SHP_RUN: begin
                if (sleep_event_i) begin
                    mode_d  = shp_pkg::SHP_STANDBY_INIT_N;
                    sleep_d = 1'b1;
                    low_d   = '0;
                end else if (!standby_init_n_i && armed_q) begin
                    low_d = low_q + 1'b1;
                    if (low_q == shp_pkg::CNT_W'(STANDBY_INIT_N_MIN_CYCLES - 1)) begin
                        mode_d  = shp_pkg::SHP_STANDBY_INIT_N;
                        sleep_d = 1'b0;
                    end
                end else if (low_q != '0) begin
                    low_d  = '0;
                    init_d = 1'b1;
                    mode_d = shp_pkg::SHP_INIT;
                end
            end
            shp_pkg::SHP_STANDBY_INIT_N: begin
                if (!standby_init_n_i) begin
                    if (low_q != shp_pkg::CNT_W'(shp_pkg::WAKE_MIN_CYC)) begin
                        low_d = low_q + 1'b1;
                    end
                end else if (sleep_q) begin
                    low_d = '0;
                    if (low_q == shp_pkg::CNT_W'(shp_pkg::WAKE_MIN_CYC)) begin
                        mode_d = shp_pkg::SHP_RUN;
                    end
                end else begin
                    low_d  = '0;
                    mode_d = shp_pkg::SHP_RUN;
                end
            end
            shp_pkg::SHP_INIT: begin
                if (param_init_done_i) begin
                    ann_d  = 1'b1;
                    mode_d = shp_pkg::SHP_RUN;
                end
            end
            default: mode_d = shp_pkg::SHP_RUN;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mode_q  <= shp_pkg::SHP_RUN;
            low_q   <= '0;
            armed_q <= 1'b0;
            sleep_q <= 1'b0;
            init_q  <= 1'b0;
            ann_q   <= 1'b0;
        end else begin
            mode_q  <= mode_d;
            low_q   <= low_d;
            armed_q <= armed_d;
            sleep_q <= sleep_d;
            init_q  <= init_d;
            ann_q   <= ann_d;
        end
    end

    // Shortest low run of 217 cycles or more on the detect pin is taken as one bit time.
    always_comb begin
        bd_prev_d = baud_detect_in_i;
        bd_run_d  = bd_run_q;
        bd_best_d = bd_best_q;
        if (!baud_detect_in_i && run) begin
            if (bd_run_q != '1) begin
                bd_run_d = bd_run_q + 1'b1;
            end
        end else begin
            bd_run_d = '0;
            if (!bd_prev_q && bd_run_q >= shp_pkg::AUTO_MIN_CYC &&
                (bd_best_q == '0 || bd_run_q < bd_best_q)) begin
                bd_best_d = bd_run_q;
            end
        end
        if (flush) begin
            bd_best_d = '0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            bd_prev_q <= 1'b1;
            bd_run_q  <= '0;
            bd_best_q <= '0;
        end else begin
            bd_prev_q <= bd_prev_d;
            bd_run_q  <= bd_run_d;
            bd_best_q <= bd_best_d;
        end
    end

    always_comb begin
        lnk.bit_cyc = shp_pkg::baud_bit_cycles(baud_select_i);
        if (baud_select_i == shp_pkg::BAUD_AUTO && bd_best_q != '0) begin
            lnk.bit_cyc = bd_best_q;
        end
    end

    assign lnk.en       = run;
    assign lnk.tx_data  = txb_q;
    assign lnk.tx_start = start_q;

    shp_uart_rx u_rx (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .rxd_i     (rxd_i),
        .lnk       (lnk.rx)
    );

    shp_uart_tx u_tx (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .txd_o     (txd_o),
        .lnk       (lnk.tx)
    );

    assign fill  = wr_q - rd_q;
    assign full  = (fill == (shp_pkg::BUF_AW + 1)'(shp_pkg::BUF_DEPTH));
    assign wr_en = lnk.rx_valid && !full && run;

    always_comb begin
        wr_d    = wr_q + (shp_pkg::BUF_AW + 1)'(wr_en);
        rd_d    = rd_q;
        out_d   = out_q;
        ov_d    = ov_q;
        ack_d   = (ack_q != '0) ? ack_q - 1'b1 : ack_q;
        start_d = 1'b0;
        txb_d   = txb_q;
        conv_d  = !converter_clear_n_i;
        if ((!ov_q || buf_ready_i) && fill != '0) begin
            out_d = mem[rd_q[shp_pkg::BUF_AW-1:0]];
            ov_d  = 1'b1;
            rd_d  = rd_q + 1'b1;
        end else if (buf_ready_i) begin
            ov_d = 1'b0;
        end
        if (lnk.rx_valid && run) begin
            ack_d = 8'(shp_pkg::ACK_CYC);
        end
        if (tx_valid_i && tx_ready_o) begin
            start_d = 1'b1;
            txb_d   = tx_data_i;
        end
        if (flush) begin
            wr_d  = '0;
            rd_d  = '0;
            ov_d  = 1'b0;
            ack_d = '0;
        end
        cts_n_d = flush || full || (ack_d != '0) || (lnk.rx_valid && run);
    end

    always_ff @(posedge clk_sys_i) begin
        if (wr_en) begin
            mem[wr_q[shp_pkg::BUF_AW-1:0]] <= lnk.rx_data;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            wr_q    <= '0;
            rd_q    <= '0;
            out_q   <= '0;
            ov_q    <= 1'b0;
            ack_q   <= '0;
            cts_n_q <= 1'b1;
            conv_q  <= 1'b1;
            start_q <= 1'b0;
            txb_q   <= '0;
        end else begin
            wr_q    <= wr_d;
            rd_q    <= rd_d;
            out_q   <= out_d;
            ov_q    <= ov_d;
            ack_q   <= ack_d;
            cts_n_q <= cts_n_d;
            conv_q  <= conv_d;
            start_q <= start_d;
            txb_q   <= txb_d;
        end
    end

    assign cts_n_o            = cts_n_q;
    assign buf_data_o         = out_q;
    assign buf_valid_o        = ov_q;
    assign tx_ready_o         = run && !lnk.tx_busy && !start_q;
    assign param_init_o       = init_q;
    assign announce_version_o = ann_q;
    assign standby_o          = (mode_q == shp_pkg::SHP_STANDBY_INIT_N);
    assign converter_init_o   = conv_q;
endmodule : shp_serial_port

// [dv/shp_serial_port_monitor.sv]
// Concurrent checks on the serial host port pins.
module shp_serial_port_monitor #(
    parameter int unsigned STANDBY_INIT_N_MIN_CYCLES = shp_pkg::STANDBY_INIT_N_MIN_CYC
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic txd_o,
    input wire logic cts_n_o,
    input wire logic standby_init_n_i,
    input wire logic converter_clear_n_i,
    input wire logic buf_valid_o,
    input wire logic tx_valid_i,
    input wire logic tx_ready_o,
    input wire logic param_init_o,
    input wire logic param_init_done_i,
    input wire logic announce_version_o,
    input wire logic standby_o,
    input wire logic converter_init_o
);
    logic [31:0] low_cnt_q;
    logic [31:0] low_cnt_d;

    always_comb begin
        low_cnt_d = (standby_init_n_i || standby_o) ? 32'h0 : low_cnt_q + 32'h1;
    end

    always_ff @(posedge clk_sys_i) begin
        low_cnt_q <= srst_i ? 32'h0 : low_cnt_d;
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    sequence s_tx_go;
        tx_valid_i && tx_ready_o;
    endsequence
    sequence s_init_pulse;
        param_init_o ##1 !param_init_o;
    endsequence

    property p_reset_idle;
        $fell(srst_i) |-> txd_o && cts_n_o && !standby_o ##1 !cts_n_o;
    endproperty
    property p_tx_start;
        s_tx_go |-> ##2 !txd_o;
    endproperty
    property p_tx_hold;
        s_tx_go |=> !tx_ready_o [*8];
    endproperty
    property p_cts_ack;
        $rose(cts_n_o) && !standby_o |=> cts_n_o [*8];
    endproperty
    property p_standby_init_n_quiet;
        standby_o && $past(standby_o) |-> cts_n_o && !tx_ready_o && !buf_valid_o;
    endproperty
    property p_standby_init_n_enter;
        !standby_o && low_cnt_q == STANDBY_INIT_N_MIN_CYCLES - 1 |-> ##[0:2] standby_o;
    endproperty
    property p_wake;
        standby_o && $rose(standby_init_n_i) |-> ##[1:2] !standby_o;
    endproperty
    property p_init_go;
        !standby_o && $rose(standby_init_n_i) |-> ##[1:2] s_init_pulse;
    endproperty
    property p_announce;
        $rose(param_init_done_i) |-> ##[1:2] announce_version_o ##1 !announce_version_o;
    endproperty
    property p_conv;
        $stable(converter_clear_n_i) |-> converter_init_o != converter_clear_n_i;
    endproperty

    a_reset_idle: assert property (p_reset_idle)
        else $error("pins not idle after reset");
    a_tx_start: assert property (p_tx_start)
        else $error("start bit late");
    a_tx_hold: assert property (p_tx_hold)
        else $error("transmit ready during frame");
    a_cts_ack: assert property (p_cts_ack)
        else $error("clear to send pulse too short");
    a_standby_init_n_quiet: assert property (p_standby_init_n_quiet)
        else $error("handshake active in standby");
    a_standby_init_n_enter: assert property (p_standby_init_n_enter)
        else $error("standby not entered");
    a_wake: assert property (p_wake)
        else $error("standby not left");
    a_init_go: assert property (p_init_go)
        else $error("no initialization pulse");
    a_announce: assert property (p_announce)
        else $error("no version pulse");
    a_conv: assert property (p_conv)
        else $error("converter init wrong");
endmodule : shp_serial_port_monitor

bind shp_serial_port shp_serial_port_monitor #(.STANDBY_INIT_N_MIN_CYCLES(STANDBY_INIT_N_MIN_CYCLES)) u_mon (
    .clk_sys_i, .srst_i, .txd_o, .cts_n_o, .standby_init_n_i, .converter_clear_n_i,
    .buf_valid_o, .tx_valid_i, .tx_ready_o, .param_init_o, .param_init_done_i,
    .announce_version_o, .standby_o, .converter_init_o
);

// [dv/shp_host_model.sv]
// Host controller model on the serial link.
module shp_host_model (
    input  wire logic clk_sys_i,
    input  wire logic txd_i,
    input  wire logic cts_n_i,
    output logic      rxd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int         bit_cyc = 1736;
    logic [7:0] got_q;
    logic       stop_ok;

    initial rxd_o = 1'b1;

    // waits for clear, sends lsb first
    task automatic send(input logic [7:0] b);
        while (cts_n_i !== 1'b0) @(negedge clk_sys_i);
        for (int i = 0; i < 10; i++) begin
            rxd_o = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
            repeat (bit_cyc) @(negedge clk_sys_i);
        end
    endtask : send

    always begin
        @(negedge txd_i);
        repeat (bit_cyc / 2) @(posedge clk_sys_i);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge clk_sys_i);
            got_q[i] = txd_i;
        end
        repeat (bit_cyc) @(posedge clk_sys_i);
        stop_ok = txd_i;
    end
endmodule : shp_host_model

// [dv/testbench.sv]
// Self-checking bench for the serial host port.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned STANDBY_INIT_N_CYC = 200;
    localparam int          LIMIT    = 70000;
    logic       clk = 1'b0, srst = 1'b1, clr_n = 1'b0, standby_init_n_n = 1'b1;
    logic       rxd, txd, cts_n, bd_n = 1'b1, sleep_ev = 1'b0;
    logic [2:0] baud_sel = 3'h6;
    logic [7:0] buf_data, tx_data = 8'h00, seed = 8'h40, b0, b1;
    logic       buf_valid, buf_ready = 1'b0, tx_valid = 1'b0, tx_ready;
    logic       pinit, pinit_done = 1'b0, announce, standby, conv_init;
    int         failures = 0, checks = 0, cyc = 0, pinit_seen = 0, ann_seen = 0;

    always #5 clk = ~clk;

    shp_serial_port #(.STANDBY_INIT_N_MIN_CYCLES(STANDBY_INIT_N_CYC)) dut (
        .clk_sys_i(clk), .srst_i(srst), .rxd_i(rxd), .txd_o(txd), .cts_n_o(cts_n),
        .baud_detect_in_i(rxd & bd_n), .baud_select_i(baud_sel),
        .standby_init_n_i(standby_init_n_n), .converter_clear_n_i(clr_n),
        .sleep_event_i(sleep_ev), .buf_data_o(buf_data), .buf_valid_o(buf_valid),
        .buf_ready_i(buf_ready), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
        .tx_ready_o(tx_ready), .param_init_o(pinit), .param_init_done_i(pinit_done),
        .announce_version_o(announce), .standby_o(standby), .converter_init_o(conv_init)
    );

    shp_host_model host (.clk_sys_i(clk), .txd_i(txd), .cts_n_i(cts_n), .rxd_o(rxd));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic drain(input logic [7:0] exp);
        int n;
        n = 0;
        while (buf_valid !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        check("buf_valid", 8'h1, {7'h0, buf_valid});
        check("buf_data", exp, buf_data);
        buf_ready = 1'b1;
        @(negedge clk);
        buf_ready = 1'b0;
    endtask : drain

    task automatic send_tx(input logic [7:0] b);
        int n;
        n = 0;
        tx_data = b;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        tx_valid = 1'b0;
    endtask : send_tx

    always @(posedge clk) begin
        cyc++;
        if (pinit === 1'b1) pinit_seen++;
        if (announce === 1'b1) ann_seen++;
        if (cyc == LIMIT) begin
            failures++;
            $display("unexpected timeout: expected done, seen %0d cycles", cyc);
            tally_and_finish();
        end
    end

    initial begin
        // mode pin high while reset held
        repeat (12) @(negedge clk);
        srst = 1'b0;
        clr_n = 1'b1;
        repeat (3) @(negedge clk);
        check("txd", 8'h1, {7'h0, txd});
        check("cts_n", 8'h0, {7'h0, cts_n});
        check("converter_init", 8'h0, {7'h0, conv_init});
        b0 = lfsr(seed);
        b1 = lfsr(b0);
        seed = b1;
        host.send(b0);
        host.send(b1);
        drain(b0);
        drain(b1);
        baud_sel = 3'h7;
        bd_n = 1'b0;
        repeat (434) @(negedge clk);
        bd_n = 1'b1;
        host.bit_cyc = 434;
        repeat (20) @(negedge clk);
        seed = lfsr(seed);
        send_tx(seed);
        repeat (4500) @(negedge clk);
        check("tx byte", seed, host.got_q);
        check("tx stop", 8'h1, {7'h0, host.stop_ok});
        host.send(8'h00);
        host.send(8'hff);
        drain(8'h00);
        standby_init_n_n = 1'b0;
        repeat (STANDBY_INIT_N_CYC + 4) @(negedge clk);
        tx_valid = 1'b1;
        @(negedge clk);
        check("standby", 8'h1, {7'h0, standby});
        check("cts_n", 8'h1, {7'h0, cts_n});
        check("buf_valid", 8'h0, {7'h0, buf_valid});
        check("tx_ready", 8'h0, {7'h0, tx_ready});
        tx_valid = 1'b0;
        standby_init_n_n = 1'b1;
        repeat (4) @(negedge clk);
        check("standby", 8'h0, {7'h0, standby});
        check("cts_n", 8'h0, {7'h0, cts_n});
        check("txd", 8'h1, {7'h0, txd});
        standby_init_n_n = 1'b0;
        repeat (5) @(negedge clk);
        standby_init_n_n = 1'b1;
        repeat (4) @(negedge clk);
        check("param_init", 8'h1, pinit_seen[7:0]);
        pinit_done = 1'b1;
        @(negedge clk);
        pinit_done = 1'b0;
        repeat (4) @(negedge clk);
        check("announce", 8'h1, ann_seen[7:0]);
        sleep_ev = 1'b1;
        @(negedge clk);
        sleep_ev = 1'b0;
        repeat (3) @(negedge clk);
        check("standby", 8'h1, {7'h0, standby});
        standby_init_n_n = 1'b0;
        repeat (30) @(negedge clk);
        standby_init_n_n = 1'b1;
        repeat (4) @(negedge clk);
        check("standby", 8'h0, {7'h0, standby});
        clr_n = 1'b0;
        repeat (3) @(negedge clk);
        check("converter_init", 8'h1, {7'h0, conv_init});
        clr_n = 1'b1;
        repeat (3) @(negedge clk);
        check("converter_init", 8'h0, {7'h0, conv_init});
        tally_and_finish();
    end
endmodule : testbench
